// ==== inc/supply_fault_map.svh ====
// Function
// RL1: Check byte upper nibble emulated only in first user programming state.
// RL2: Marker bits 11 and 10 not user writable; NVM controller sets them.
// RL3: Each 24-bit word carries 4-bit check field in bits 3..0.
// RL4: Word1 bit 22 reads boost timer expired.
// RL5: Word1 bit 21 set on deep sleep forced by 15 dog fails.
// RL6: Buck C overcurrent, overvoltage, undervoltage in word1 bits 20, 19, 18.
// RL7: Buck B flags in bits 16..14, buck A flags in bits 12..10.
// RL8: Buck good timeout sets bit 17, 13 or 9, held until read-clear.
// RL9: Linreg B good timeout after serial turn-on sets word1 bit 8.
// RL10: Linreg A good timeout after serial turn-on sets word1 bit 5.
// RL11: Linreg B undervoltage and overvoltage latch bits 7 and 6.
// RL12: Linreg A undervoltage latches word1 bit 4.
// RL13: High side open load and overcurrent latch word2 bits 22, 21.
// RL14: Word2 bit 20 boost in low power; bits 19, 18 switch monitor errors.
// RL15: Boost feedback overvoltage bit 17, undervoltage bit 16, latched.
// RL16: Boost feedback event in active or first recovery pulses interrupt output.
// RL17: Word2 bit 15 set when interrupt driven low but echo high.
// RL18: Echo mismatches of collect enable, failsafe, dog enable in bits 14..12.
// RL19: Bit 11 set when reset pin reads high while driven low.
// RL20: I/O supply undervoltage latches word2 bit 10.
// RL21: Thermal cut clusters 4..0 latch bits 9..5 until read-clear.
// RL22: Bit 4 is OR of cluster cut flags, not directly clearable.
// RL23: Read-clear bits reset to 0 and set again only on new events.
`ifndef SUPPLY_FAULT_MAP_SVH
`define SUPPLY_FAULT_MAP_SVH
`define NVM_WORD_IDX 8'h19
`define REG_FAULT_IDX 8'h21
`define BOOST_THERM_IDX 8'h22
`define NVM_WORD_ADDR 12'h064
`define REG_FAULT_ADDR 12'h084
`define BOOST_THERM_ADDR 12'h088
`define CTRL_ADDR 12'h100
`define CHECK_MSB 3
`define CHECK_LSB 0
`define EMUL_MSB 19
`define EMUL_LSB 16
`define MARKER_MSB 11
`define MARKER_LSB 10
`define W1_BOOST_TMR 22
`define W1_DOG_SLEEP 21
`define W1_RC_MASK 24'h3FFFF0
`define W2_RC_MASK 24'h7FFFE0
`define W2_SUMMARY 4
`define CTRL_CLEAR_BIT 0
`define NVM_RESET 24'h000000
`endif

// ==== inc/supply_fault_pkg.sv ====
package supply_fault_pkg;
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_WRITE = 3'b010,
        BUS_READ = 3'b100
    } bus_phase_e;
    typedef struct packed {
        bus_phase_e phase;
        logic [11:0] addr;
        logic [23:0] nvm_word;
        logic [23:0] fault1;
        logic [23:0] fault2;
        logic [31:0] rdata;
        logic irq_pulse;
        logic [1:0] fb_prev;
        logic rc_mode;
    } bank_state_s;
endpackage : supply_fault_pkg

// ==== verilog/supply_fault_status_bank.sv ====
`timescale 1ns/1ns
`include "supply_fault_map.svh"
module supply_fault_status_bank
    import supply_fault_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic user_programming_state,
    input wire logic nvm_marker_load,
    input wire logic [1:0] nvm_marker_value,
    input wire logic [3:0] check_w0,
    input wire logic [3:0] check_w1,
    input wire logic [3:0] check_w2,
    input wire logic boost_timer_expired,
    input wire logic sleep_forced_by_dog_fails,
    input wire logic [2:0] buck_overcurrent,
    input wire logic [2:0] buck_overvoltage,
    input wire logic [2:0] buck_undervoltage,
    input wire logic [2:0] buck_good_timeout,
    input wire logic linreg_b_good_timeout,
    input wire logic linreg_a_good_timeout,
    input wire logic linreg_b_undervoltage,
    input wire logic linreg_b_overvoltage,
    input wire logic linreg_a_undervoltage,
    input wire logic high_side_open_load,
    input wire logic high_side_overcurrent,
    input wire logic boost_on_in_low_power,
    input wire logic bypass_switch_monitor_error,
    input wire logic boost_switch_monitor_error,
    input wire logic boost_feedback_overvoltage,
    input wire logic boost_feedback_undervoltage,
    input wire logic active_or_first_recovery_mode,
    input wire logic irq_drive_low,
    input wire logic irq_echo,
    input wire logic fault_collect_enable_echo_error,
    input wire logic failsafe_out_echo_error,
    input wire logic dog_enable_echo_error,
    input wire logic reset_drive_low,
    input wire logic reset_pin_filtered,
    input wire logic io_supply_undervoltage,
    input wire logic [4:0] thermal_cut_cluster,
    output logic irq_pulse,
    output logic [23:0] nvm_word
);
    bank_state_s st_r;
    bank_state_s st_nxt;
    logic [23:0] w1_set;
    logic [23:0] w2_set;
    logic [23:0] w1_view;
    logic [23:0] w2_view;
    logic addr_take;

    default clocking dflt_cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    // Merge an event vector into a read-clear word; set wins over clear
    function automatic logic [23:0] latch_word(input logic [23:0] cur, input logic [23:0] set,
                                               input logic clr, input logic [23:0] mask);
        logic [23:0] kept;
        kept = clr ? 24'h000000 : cur;
        return (kept | set) & mask; // RL23
    endfunction : latch_word

    // Place a check field in the low nibble of a word
    function automatic logic [23:0] with_check(input logic [23:0] w, input logic [3:0] c);
        return {w[23:4], c}; // RL3
    endfunction : with_check

    always_comb begin
        w1_set = 24'h000000;
        w1_set[20] = buck_overcurrent[2]; // RL6
        w1_set[19] = buck_overvoltage[2]; // RL6
        w1_set[18] = buck_undervoltage[2]; // RL6
        w1_set[17] = buck_good_timeout[2]; // RL8
        w1_set[16] = buck_overcurrent[1]; // RL7
        w1_set[15] = buck_overvoltage[1]; // RL7
        w1_set[14] = buck_undervoltage[1]; // RL7
        w1_set[13] = buck_good_timeout[1]; // RL8
        w1_set[12] = buck_overcurrent[0]; // RL7
        w1_set[11] = buck_overvoltage[0]; // RL7
        w1_set[10] = buck_undervoltage[0]; // RL7
        w1_set[9] = buck_good_timeout[0]; // RL8
        w1_set[8] = linreg_b_good_timeout; // RL9
        w1_set[7] = linreg_b_undervoltage; // RL11
        w1_set[6] = linreg_b_overvoltage; // RL11
        w1_set[5] = linreg_a_good_timeout; // RL10
        w1_set[4] = linreg_a_undervoltage; // RL12
        w1_set[`W1_DOG_SLEEP] = sleep_forced_by_dog_fails; // RL5
        w2_set = 24'h000000;
        w2_set[22] = high_side_open_load; // RL13
        w2_set[21] = high_side_overcurrent; // RL13
        w2_set[20] = boost_on_in_low_power; // RL14
        w2_set[19] = bypass_switch_monitor_error; // RL14
        w2_set[18] = boost_switch_monitor_error; // RL14
        w2_set[17] = boost_feedback_overvoltage; // RL15
        w2_set[16] = boost_feedback_undervoltage; // RL15
        w2_set[15] = irq_drive_low & irq_echo; // RL17
        w2_set[14] = fault_collect_enable_echo_error; // RL18
        w2_set[13] = failsafe_out_echo_error; // RL18
        w2_set[12] = dog_enable_echo_error; // RL18
        w2_set[11] = reset_drive_low & reset_pin_filtered; // RL19
        w2_set[10] = io_supply_undervoltage; // RL20
        w2_set[9:5] = thermal_cut_cluster; // RL21
    end

    // Read views: timer bit is live, summary is OR of cluster flags
    always_comb begin
        w1_view = with_check(st_r.fault1, check_w1);
        w1_view[`W1_BOOST_TMR] = boost_timer_expired; // RL4
        w2_view = with_check(st_r.fault2, check_w2);
        w2_view[`W2_SUMMARY] = |st_r.fault2[9:5]; // RL22
    end

    assign addr_take = hsel & hready & htrans[1];

    always_comb begin
        st_nxt = st_r;
        st_nxt.phase = BUS_IDLE;
        st_nxt.irq_pulse = 1'b0;
        st_nxt.fb_prev = {boost_feedback_overvoltage, boost_feedback_undervoltage};
        if (addr_take) begin
            st_nxt.addr = haddr[11:0];
            st_nxt.phase = hwrite ? BUS_WRITE : BUS_READ;
            st_nxt.rdata = 32'h00000000;
            case (haddr[11:0])
                `NVM_WORD_ADDR: st_nxt.rdata = {8'h00, with_check(st_r.nvm_word, check_w0)};
                `REG_FAULT_ADDR: st_nxt.rdata = {8'h00, w1_view};
                `BOOST_THERM_ADDR: st_nxt.rdata = {8'h00, w2_view};
                `CTRL_ADDR: st_nxt.rdata = {31'h00000000, st_r.rc_mode};
                default: st_nxt.rdata = 32'h00000000;
            endcase
        end
        st_nxt.fault1 = latch_word(st_r.fault1, w1_set,
            addr_take && !hwrite && st_r.rc_mode && haddr[11:0] == `REG_FAULT_ADDR,
            `W1_RC_MASK);
        st_nxt.fault2 = latch_word(st_r.fault2, w2_set,
            addr_take && !hwrite && st_r.rc_mode && haddr[11:0] == `BOOST_THERM_ADDR,
            `W2_RC_MASK);
        // Rising edge of a feedback fault in the right modes pulses the interrupt
        if (active_or_first_recovery_mode &&
            (|({boost_feedback_overvoltage, boost_feedback_undervoltage} & ~st_r.fb_prev))) begin
            st_nxt.irq_pulse = 1'b1; // RL16
        end
        case (st_r.phase)
            BUS_WRITE: begin
                if (st_r.addr == `NVM_WORD_ADDR && user_programming_state) begin
                    st_nxt.nvm_word[`EMUL_MSB:`EMUL_LSB] = hwdata[`EMUL_MSB:`EMUL_LSB]; // RL1
                end
                if (st_r.addr == `CTRL_ADDR) begin
                    st_nxt.rc_mode = hwdata[`CTRL_CLEAR_BIT];
                end
            end
            BUS_READ: ;
            BUS_IDLE: ;
            default: st_nxt.phase = BUS_IDLE;
        endcase
        if (nvm_marker_load) begin
            st_nxt.nvm_word[`MARKER_MSB:`MARKER_LSB] = nvm_marker_value; // RL2
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_r <= '{phase: BUS_IDLE,
                      addr: 12'h000,
                      nvm_word: `NVM_RESET,
                      fault1: 24'h000000,
                      fault2: 24'h000000,
                      rdata: 32'h00000000,
                      irq_pulse: 1'b0,
                      fb_prev: 2'b00,
                      rc_mode: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hrdata = st_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq_pulse = st_r.irq_pulse;
    assign nvm_word = with_check(st_r.nvm_word, check_w0);

    a_marker_guard: assert property (@(posedge sys_clk) disable iff (reset) // RL2
        !nvm_marker_load |=> $stable(st_r.nvm_word[11:10]))
        else $error("marker bits changed without controller load");
    a_emul_gate: assert property (@(posedge sys_clk) disable iff (reset) // RL1
        (st_r.phase == BUS_WRITE && !user_programming_state)
            |=> $stable(st_r.nvm_word[19:16]))
        else $error("emulated nibble written outside programming state");
    a_buck_latch: assert property (@(posedge sys_clk) disable iff (reset) // RL8
        buck_good_timeout[2] |=> st_r.fault1[17])
        else $error("buck timeout flag not latched");
    a_sleep_flag: assert property (@(posedge sys_clk) disable iff (reset) // RL5
        sleep_forced_by_dog_fails |=> st_r.fault1[21])
        else $error("dog sleep flag not set");
    a_rc_hold: assert property (@(posedge sys_clk) disable iff (reset) // RL23
        (st_r.fault2[10] && !addr_take) |=> st_r.fault2[10])
        else $error("latched flag dropped without read");
    a_irq_pulse: assert property (@(posedge sys_clk) disable iff (reset) // RL16
        irq_pulse |=> !irq_pulse)
        else $error("interrupt pulse longer than one cycle");
    a_irq_cause: assert property (@(posedge sys_clk) disable iff (reset) // RL16
        (active_or_first_recovery_mode && boost_feedback_overvoltage && !st_r.fb_prev[1])
            |=> irq_pulse && st_r.fault2[17])
        else $error("feedback event gave no pulse");
    a_echo_flag: assert property (@(posedge sys_clk) disable iff (reset) // RL17
        (irq_drive_low && irq_echo) |=> st_r.fault2[15])
        else $error("interrupt echo error not flagged");
    a_summary_or: assert property (@(posedge sys_clk) disable iff (reset) // RL22
        w2_view[4] == (st_r.fault2[9:5] != 5'h00))
        else $error("summary bit not OR of clusters");
    a_check_low: assert property (@(posedge sys_clk) disable iff (reset) // RL3
        w1_view[3:0] == check_w1)
        else $error("check field misplaced");

    a_buck_c_oc: assert property ( // RL6
        buck_overcurrent[2] |=> st_r.fault1[20])
        else $error("buck c overcurrent lost");
    a_buck_c_ov: assert property ( // RL6
        buck_overvoltage[2] |=> st_r.fault1[19])
        else $error("buck c overvoltage lost");
    a_buck_c_uv: assert property ( // RL6
        buck_undervoltage[2] |=> st_r.fault1[18])
        else $error("buck c undervoltage lost");
    a_buck_b_oc: assert property ( // RL7
        buck_overcurrent[1] |=> st_r.fault1[16])
        else $error("buck b overcurrent lost");
    a_buck_b_ov: assert property ( // RL7
        buck_overvoltage[1] |=> st_r.fault1[15])
        else $error("buck b overvoltage lost");
    a_buck_b_uv: assert property ( // RL7
        buck_undervoltage[1] |=> st_r.fault1[14])
        else $error("buck b undervoltage lost");
    a_buck_b_tmo: assert property ( // RL8
        buck_good_timeout[1] |=> st_r.fault1[13])
        else $error("buck b timeout lost");
    a_buck_a_oc: assert property ( // RL7
        buck_overcurrent[0] |=> st_r.fault1[12])
        else $error("buck a overcurrent lost");
    a_buck_a_ov: assert property ( // RL7
        buck_overvoltage[0] |=> st_r.fault1[11])
        else $error("buck a overvoltage lost");
    a_buck_a_uv: assert property ( // RL7
        buck_undervoltage[0] |=> st_r.fault1[10])
        else $error("buck a undervoltage lost");
    a_buck_a_tmo: assert property ( // RL8
        buck_good_timeout[0] |=> st_r.fault1[9])
        else $error("buck a timeout lost");
    a_linreg_b_tmo: assert property ( // RL9
        linreg_b_good_timeout |=> st_r.fault1[8])
        else $error("linreg b timeout lost");
    a_linreg_b_uv: assert property ( // RL11
        linreg_b_undervoltage |=> st_r.fault1[7])
        else $error("linreg b undervoltage lost");
    a_linreg_b_ov: assert property ( // RL11
        linreg_b_overvoltage |=> st_r.fault1[6])
        else $error("linreg b overvoltage lost");
    a_linreg_a_tmo: assert property ( // RL10
        linreg_a_good_timeout |=> st_r.fault1[5])
        else $error("linreg a timeout lost");
    a_linreg_a_uv: assert property ( // RL12
        linreg_a_undervoltage |=> st_r.fault1[4])
        else $error("linreg a undervoltage lost");

    a_hs_open_load: assert property ( // RL13
        high_side_open_load |=> st_r.fault2[22])
        else $error("open load lost");
    a_hs_overcurrent: assert property ( // RL13
        high_side_overcurrent |=> st_r.fault2[21])
        else $error("high side overcurrent lost");
    a_boost_low_power: assert property ( // RL14
        boost_on_in_low_power |=> st_r.fault2[20])
        else $error("boost low power flag lost");
    a_bypass_mon_err: assert property ( // RL14
        bypass_switch_monitor_error |=> st_r.fault2[19])
        else $error("bypass monitor flag lost");
    a_boost_mon_err: assert property ( // RL14
        boost_switch_monitor_error |=> st_r.fault2[18])
        else $error("boost monitor flag lost");
    a_fb_ov_latch: assert property ( // RL15
        boost_feedback_overvoltage |=> st_r.fault2[17])
        else $error("feedback overvoltage lost");
    a_fb_uv_latch: assert property ( // RL15
        boost_feedback_undervoltage |=> st_r.fault2[16])
        else $error("feedback undervoltage lost");
    a_collect_echo: assert property ( // RL18
        fault_collect_enable_echo_error |=> st_r.fault2[14])
        else $error("collect echo flag lost");
    a_failsafe_echo: assert property ( // RL18
        failsafe_out_echo_error |=> st_r.fault2[13])
        else $error("failsafe echo flag lost");
    a_dog_echo: assert property ( // RL18
        dog_enable_echo_error |=> st_r.fault2[12])
        else $error("dog echo flag lost");
    a_reset_echo: assert property ( // RL19
        (reset_drive_low && reset_pin_filtered) |=> st_r.fault2[11])
        else $error("reset echo flag lost");
    a_io_supply_uv: assert property ( // RL20
        io_supply_undervoltage |=> st_r.fault2[10])
        else $error("io supply flag lost");
    a_therm_cl4: assert property ( // RL21
        thermal_cut_cluster[4] |=> st_r.fault2[9])
        else $error("cluster 4 flag lost");
    a_therm_cl3: assert property ( // RL21
        thermal_cut_cluster[3] |=> st_r.fault2[8])
        else $error("cluster 3 flag lost");
    a_therm_cl2: assert property ( // RL21
        thermal_cut_cluster[2] |=> st_r.fault2[7])
        else $error("cluster 2 flag lost");
    a_therm_cl1: assert property ( // RL21
        thermal_cut_cluster[1] |=> st_r.fault2[6])
        else $error("cluster 1 flag lost");
    a_therm_cl0: assert property ( // RL21
        thermal_cut_cluster[0] |=> st_r.fault2[5])
        else $error("cluster 0 flag lost");

    a_w1_clear: assert property ( // RL23
        (addr_take && !hwrite && st_r.rc_mode && w1_set == 24'h000000 &&
            haddr[11:0] == `REG_FAULT_ADDR) |=> st_r.fault1 == 24'h000000)
        else $error("word1 not cleared by read");
    a_w2_clear: assert property ( // RL23
        (addr_take && !hwrite && st_r.rc_mode && w2_set == 24'h000000 &&
            haddr[11:0] == `BOOST_THERM_ADDR) |=> st_r.fault2 == 24'h000000)
        else $error("word2 not cleared by read");
    a_w1_sticky: assert property ( // RL23
        !(addr_take && !hwrite && st_r.rc_mode) |=>
            (st_r.fault1 & $past(st_r.fault1)) == $past(st_r.fault1))
        else $error("word1 flag dropped");
    a_w2_sticky: assert property ( // RL23
        !(addr_take && !hwrite && st_r.rc_mode) |=>
            (st_r.fault2 & $past(st_r.fault2)) == $past(st_r.fault2))
        else $error("word2 flag dropped");
    a_w1_quiet: assert property ( // RL23
        (st_r.fault1 == 24'h000000 && w1_set == 24'h000000) |=> st_r.fault1 == 24'h000000)
        else $error("word1 flag set without event");
    a_w2_quiet: assert property ( // RL23
        (st_r.fault2 == 24'h000000 && w2_set == 24'h000000) |=> st_r.fault2 == 24'h000000)
        else $error("word2 flag set without event");

    a_timer_live: assert property ( // RL4
        w1_view[`W1_BOOST_TMR] == boost_timer_expired)
        else $error("timer bit not live");
    a_w2_check: assert property ( // RL3
        w2_view[3:0] == check_w2)
        else $error("word2 check field misplaced");
    a_nvm_check: assert property ( // RL3
        nvm_word[3:0] == check_w0)
        else $error("nvm check field misplaced");
    a_rdata_top: assert property ( // RL3
        hrdata[31:24] == 8'h00)
        else $error("read data above word");
    a_irq_quiet: assert property ( // RL16
        !active_or_first_recovery_mode |=> !irq_pulse)
        else $error("interrupt pulse outside modes");
    a_emul_write: assert property ( // RL1
        (st_r.phase == BUS_WRITE && st_r.addr == `NVM_WORD_ADDR && user_programming_state)
            |=> st_r.nvm_word[19:16] == $past(hwdata[19:16]))
        else $error("emulated nibble not written");
    a_marker_load: assert property ( // RL2
        nvm_marker_load |=> st_r.nvm_word[11:10] == $past(nvm_marker_value))
        else $error("marker bits not loaded");
    a_nvm_fixed: assert property ( // RL1
        $stable(st_r.nvm_word[9:4]) && st_r.nvm_word[23:20] == 4'h0)
        else $error("fixed nvm bits changed");

endmodule : supply_fault_status_bank

// ==== testbench/host_model.sv ====
`timescale 1ns/1ns
module host_model (
    input wire logic sys_clk,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
    end
    // Single word transfer; waits on ready, never on a fixed count
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        hwdata <= ~wd;
    endtask : xfer
endmodule : host_model

// ==== testbench/testbench.sv ====
`timescale 1ns/1ns
`include "supply_fault_map.svh"
module testbench;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic ups = 1'b0, mload = 1'b0, mode = 1'b0, btmr = 1'b0;
    logic [23:0] e1 = '0, e2 = '0;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hsel, hwrite, hrdy, irq;
    logic [23:0] nvm;
    int err_total = 0, n_tests = 0, cyc = 0, irq_cnt = 0;
    localparam logic [3:0] C0 = 4'hA, C1 = 4'h5, C2 = 4'hC;
    always #25 sys_clk = ~sys_clk;
    host_model u_host (.sys_clk(sys_clk), .hrdata(hrdata), .hreadyout(hrdy), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    supply_fault_status_bank u_dut (.sys_clk(sys_clk), .reset(reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(),
        .user_programming_state(ups), .nvm_marker_load(mload), .nvm_marker_value(2'b10),
        .check_w0(C0), .check_w1(C1), .check_w2(C2), .boost_timer_expired(btmr),
        .sleep_forced_by_dog_fails(e1[21]), .buck_overcurrent({e1[20], e1[16], e1[12]}),
        .buck_overvoltage({e1[19], e1[15], e1[11]}),
        .buck_undervoltage({e1[18], e1[14], e1[10]}),
        .buck_good_timeout({e1[17], e1[13], e1[9]}), .linreg_b_good_timeout(e1[8]),
        .linreg_a_good_timeout(e1[5]), .linreg_b_undervoltage(e1[7]),
        .linreg_b_overvoltage(e1[6]), .linreg_a_undervoltage(e1[4]),
        .high_side_open_load(e2[22]), .high_side_overcurrent(e2[21]),
        .boost_on_in_low_power(e2[20]), .bypass_switch_monitor_error(e2[19]),
        .boost_switch_monitor_error(e2[18]), .boost_feedback_overvoltage(e2[17]),
        .boost_feedback_undervoltage(e2[16]), .active_or_first_recovery_mode(mode),
        .irq_drive_low(e2[15]), .irq_echo(e2[15]), .fault_collect_enable_echo_error(e2[14]),
        .failsafe_out_echo_error(e2[13]), .dog_enable_echo_error(e2[12]),
        .reset_drive_low(e2[11]), .reset_pin_filtered(e2[11]),
        .io_supply_undervoltage(e2[10]), .thermal_cut_cluster(e2[9:5]),
        .irq_pulse(irq), .nvm_word(nvm));
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    always @(posedge sys_clk) begin
        if (irq === 1'b1) irq_cnt++;
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish;
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        u_host.xfer(1'b0, a, 32'h0, r);
        chk(nm, exp, r);
    endtask : rd_chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        u_host.xfer(1'b1, a, d, r);
    endtask : wr
    task automatic t_reset;
        rd_chk("nvm", `NVM_WORD_ADDR, {28'h0, C0});
        rd_chk("w1", `REG_FAULT_ADDR, {28'h0, C1});
        rd_chk("w2", `BOOST_THERM_ADDR, {28'h0, C2});
        rd_chk("unmapped", 12'h0F0, 32'h0);
        chk("nvm_port", {8'h0, 20'h0, C0}, {8'h0, nvm});
    endtask : t_reset
    // One-cycle event per bit: latched, seen once, cleared by the read
    task automatic t_events;
        for (int b = 4; b < 23; b++) begin
            @(posedge sys_clk);
            if (b < 22) e1[b] <= 1'b1;
            if (b > 4) e2[b] <= 1'b1;
            @(posedge sys_clk);
            e1 <= '0;
            e2 <= '0;
            if (b < 22) rd_chk("w1_set", `REG_FAULT_ADDR, {8'h0, 24'h1 << b} | C1);
            if (b < 22) rd_chk("w1_clr", `REG_FAULT_ADDR, {28'h0, C1});
            if (b > 4) rd_chk("w2_set", `BOOST_THERM_ADDR,
                {8'h0, (24'h1 << b) | ((b < 10) ? 24'h10 : 24'h0)} | C2);
            if (b > 4) rd_chk("w2_clr", `BOOST_THERM_ADDR, {28'h0, C2});
        end
    endtask : t_events
    task automatic t_live;
        @(posedge sys_clk);
        btmr <= 1'b1;
        rd_chk("tmr_on", `REG_FAULT_ADDR, 32'h400000 | C1);
        rd_chk("tmr_held", `REG_FAULT_ADDR, 32'h400000 | C1);
        @(posedge sys_clk);
        btmr <= 1'b0;
        rd_chk("tmr_off", `REG_FAULT_ADDR, {28'h0, C1});
    endtask : t_live
    task automatic t_irq;
        int n0;
        n0 = irq_cnt;
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk);
            mode <= (k < 2);
            repeat (2) @(posedge sys_clk);
            e2[17 - (k % 2)] <= 1'b1;
            @(posedge sys_clk);
            e2 <= '0;
            repeat (4) @(posedge sys_clk);
        end
        chk("irq_cycles", 32'd2, 32'(irq_cnt - n0));
        rd_chk("fb_latched", `BOOST_THERM_ADDR, 32'h30000 | C2);
    endtask : t_irq
    task automatic t_nvm;
        wr(`NVM_WORD_ADDR, 32'h000F0C00);
        rd_chk("nvm_locked", `NVM_WORD_ADDR, {28'h0, C0});
        @(posedge sys_clk);
        ups <= 1'b1;
        wr(`NVM_WORD_ADDR, 32'h000F0C00);
        @(posedge sys_clk);
        ups <= 1'b0;
        rd_chk("nvm_emul", `NVM_WORD_ADDR, 32'h000F0000 | C0);
        @(posedge sys_clk);
        mload <= 1'b1;
        @(posedge sys_clk);
        mload <= 1'b0;
        rd_chk("nvm_marker", `NVM_WORD_ADDR, 32'h000F0800 | C0);
        chk("nvm_port", 32'h000F0800 | C0, {8'h0, nvm});
        wr(`REG_FAULT_ADDR, 32'hFFFFFFFF);
        rd_chk("status_wr", `REG_FAULT_ADDR, {28'h0, C1});
    endtask : t_nvm
    // Read-clear disabled keeps flags across reads; enabling it clears again
    task automatic t_ctrl;
        rd_chk("ctrl_rst", `CTRL_ADDR, 32'h1);
        wr(`CTRL_ADDR, 32'h0);
        @(posedge sys_clk);
        e2[10] <= 1'b1;
        @(posedge sys_clk);
        e2 <= '0;
        rd_chk("keep1", `BOOST_THERM_ADDR, 32'h400 | C2);
        rd_chk("keep2", `BOOST_THERM_ADDR, 32'h400 | C2);
        wr(`CTRL_ADDR, 32'h1);
        rd_chk("ctrl_on", `CTRL_ADDR, 32'h1);
        rd_chk("rc_on", `BOOST_THERM_ADDR, 32'h400 | C2);
        rd_chk("rc_done", `BOOST_THERM_ADDR, {28'h0, C2});
    endtask : t_ctrl
    // Reset in mid-run drops a latched flag and the emulated nvm contents
    task automatic t_rerst;
        @(posedge sys_clk);
        e1[4] <= 1'b1;
        @(posedge sys_clk);
        e1 <= '0;
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        chk("nvm_rerst", {8'h0, 20'h0, C0}, {8'h0, nvm});
        rd_chk("w1_rerst", `REG_FAULT_ADDR, {28'h0, C1});
        rd_chk("ctrl_rerst", `CTRL_ADDR, 32'h1);
    endtask : t_rerst
    initial begin
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset;
        t_events;
        t_live;
        t_irq;
        t_nvm;
        t_ctrl;
        t_rerst;
        tally_and_finish;
    end
endmodule : testbench
